// ---- rtl/serial_prog_map.vh ----
// Offsets, codes, field positions and timing counts of the serial programming sequencer
`ifndef SERIAL_PROG_MAP_VH
`define SERIAL_PROG_MAP_VH

// Command codes
`define CMD_READ_EXT     4'h2
`define CMD_PROG_EXT     4'h3
`define CMD_LOAD         4'h4
`define CMD_PROG         4'h5
`define CMD_READ         4'h6
`define CMD_INC          4'h7
`define CMD_IDLE         4'hf

// Address map
`define PRIMARY_CFG_2K   13'h0fff
`define PRIMARY_CFG_4K   13'h1fff
`define PROG_TOP_2K      13'h07ff
`define PROG_TOP_4K      13'h0fff
`define ID_WORDS         13'h0010

// Reset values and fields of the configuration words
`define CFG_RESET        12'hfff
`define EXT_TRIM_HI      11
`define EXT_PINS         10
`define EXT_TRIM_MID     9
`define EXT_TRIM_LO      8

// Frame layout
`define SYNC_CYCLE       5'h00
`define LAST_CMD_CYCLE   5'h04
`define FIRST_DATA_CYCLE 5'h05
`define LAST_DATA_CYCLE  5'h10

// Timing; the phase count is 7810 ns over a 4 ns clock, rounded down to a whole count
`define CLK_PERIOD_NS    4
`define PHASE_TIME_NS    7810
`define PHASE_CLKS       11'd1952

`endif

// ---- rtl/frame_timer.v ----
// Internal programming clock phases and frame cycle position
`timescale 1ns/1ps
`default_nettype none
`include "serial_prog_map.vh"

module frame_timer #(
  parameter [10:0] phase_clks = `PHASE_CLKS
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Control
  input  wire       run,
  // Frame position
  output reg  [4:0] cycle,
  output reg  [1:0] phase,
  output wire       phase_end
);

  reg [10:0] count;

  // 4 phases per cycle, 17 cycles per frame, about 128 kHz phase rate
  assign phase_end = run && (count == phase_clks - 11'h001);

  always @(posedge clk) begin
    if (!rst_n || !run) begin
      count <= 11'h000;
      phase <= 2'h0;
      cycle <= `SYNC_CYCLE;
    end else if (phase_end) begin
      count <= 11'h000;
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        if (cycle == `LAST_DATA_CYCLE) begin
          cycle <= `SYNC_CYCLE;
        end else begin
          cycle <= cycle + 5'h01;
        end
      end
    end else begin
      count <= count + 11'h001;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/serial_prog_access.v ----
// Memory-access sequencer behind the two-pin serial programming link
//
// Behaviour
// - Frame: sync, four command, twelve data cycles
// - Decode load, program, read, increment, config commands
// - Command 1111 idles until next frame
// - Entry points at primary configuration word address
// - Read frame shifts pointed word out
// - Increment steps pointer; config address wraps to 000h
// - Increment frame ignores its data cycles
// - Increments walk 000h up to top address
// - Pointer wraps after 4096 or 8192 steps
// - Load frame captures twelve bits for programming
// - Program frame writes held word, ignores data
// - Primary config applies only after read-back
// - Older revision applies config immediately
// - Sixteen customer-ID words follow program memory
// - Customer-ID words reachable only in programming
// - Extended bits 11,9,8 trim RC clock
// - Phase clock 128 kHz at 250 MHz
// - Extended bit 10 marks 28-pin package
// - Refuse program frames, not extended program frames, while package bit wrong
// - Exit after next sync cycle, pulse reset
`timescale 1ns/1ps
`default_nettype none
`include "serial_prog_map.vh"

module serial_prog_access (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Programming link pins
  input  wire        prog_voltage_pin,
  input  wire        serial_io_pin_in,
  output wire        serial_io_pin_out,
  output reg         serial_io_pin_oe,
  // Part straps
  input  wire        part_4k,
  input  wire        old_revision,
  input  wire        package_28,
  // Program memory port
  output reg  [12:0] mem_addr,
  input  wire [11:0] mem_rdata,
  output reg  [11:0] mem_wdata,
  output reg         mem_write,
  // Mode and applied configuration
  output reg         prog_mode,
  output reg         internal_reset,
  output reg  [11:0] primary_config_word,
  output reg  [11:0] extended_config_word,
  output wire [2:0]  clock_trim,
  output wire        pins_28
);

  // Primary configuration word address for the part
  function [12:0] cfg_addr;
    input big;
    begin
      cfg_addr = big ? `PRIMARY_CFG_4K : `PRIMARY_CFG_2K;
    end
  endfunction

  // Last program memory address for the part
  function [12:0] prog_top;
    input big;
    begin
      prog_top = big ? `PROG_TOP_4K : `PROG_TOP_2K;
    end
  endfunction

  // Address lies in the customer-ID block after program memory
  function is_id;
    input [12:0] a;
    input        big;
    begin
      is_id = (a > prog_top(big)) && (a <= prog_top(big) + `ID_WORDS);
    end
  endfunction

  // Index into the customer-ID block
  function [3:0] id_index;
    input [12:0] a;
    input        big;
    reg   [12:0] offs;
    begin
      offs = a - prog_top(big) - 13'h0001;
      id_index = offs[3:0];
    end
  endfunction

  // Straps caught while held in reset
  reg        big_part;
  reg        old_rev;
  reg        pkg_28;

  // Input synchronisers
  reg        pv_s1;
  reg        pv_s2;
  reg        pv_s3;
  reg        pv;
  reg        sio_s1;
  reg        sio_s2;
  reg        sio_s3;
  reg        sio;

  // Frame state
  reg        exit_pending;
  reg  [3:0] cmd_shift;
  reg  [3:0] cmd;
  reg [11:0] data_shift;
  reg [11:0] hold_word;
  reg [11:0] out_word;
  reg        reading;
  reg [11:0] stored_primary;
  reg [11:0] stored_extended;
  reg [11:0] id_words [0:15];
  reg [11:0] next_out;
  reg        next_oe;
  integer    i;

  wire [4:0] cycle;
  wire [1:0] phase;
  wire       phase_end;

  frame_timer frame_timer_inst (
    .clk       (clk),
    .rst_n     (rst_n),
    .run       (prog_mode),
    .cycle     (cycle),
    .phase     (phase),
    .phase_end (phase_end)
  );

  // Sample point is the start of the fourth phase
  wire       sample      = phase_end && (phase == 2'h2);
  wire       cycle_end   = phase_end && (phase == 2'h3);
  wire       frame_end   = cycle_end && (cycle == `LAST_DATA_CYCLE);
  wire       sync_end    = cycle_end && (cycle == `SYNC_CYCLE);
  wire       cmd_done    = sample && (cycle == `LAST_CMD_CYCLE);
  wire [3:0] new_cmd     = {cmd_shift[2:0], sio};
  wire       at_cfg      = (mem_addr == cfg_addr(big_part));
  wire       at_id       = is_id(mem_addr, big_part);
  wire [3:0] id_sel      = id_index(mem_addr, big_part);
  wire       pkg_ok      = (stored_extended[`EXT_PINS] == pkg_28);

  // Open drain: the pin is only ever pulled low
  assign serial_io_pin_out = 1'b0;

  assign clock_trim = {extended_config_word[`EXT_TRIM_HI],
                       extended_config_word[`EXT_TRIM_MID],
                       extended_config_word[`EXT_TRIM_LO]};
  assign pins_28    = extended_config_word[`EXT_PINS];

  always @(posedge clk) begin
    if (!rst_n) begin
      big_part <= part_4k;
      old_rev  <= old_revision;
      pkg_28   <= package_28;
    end
  end

  // Three stages; a change counts once stages two and three agree
  always @(posedge clk) begin
    if (!rst_n) begin
      pv_s1  <= 1'b0;
      pv_s2  <= 1'b0;
      pv_s3  <= 1'b0;
      pv     <= 1'b0;
      sio_s1 <= 1'b1;
      sio_s2 <= 1'b1;
      sio_s3 <= 1'b1;
      sio    <= 1'b1;
    end else begin
      pv_s1  <= prog_voltage_pin;
      pv_s2  <= pv_s1;
      pv_s3  <= pv_s2;
      sio_s1 <= serial_io_pin_in;
      sio_s2 <= sio_s1;
      sio_s3 <= sio_s2;
      if (pv_s2 == pv_s3) begin
        pv <= pv_s3;
      end
      if (sio_s2 == sio_s3) begin
        sio <= sio_s3;
      end
    end
  end

  // Mode entry and exit
  always @(posedge clk) begin
    if (!rst_n) begin
      prog_mode      <= 1'b0;
      exit_pending   <= 1'b0;
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= 1'b0;
      if (!prog_mode) begin
        exit_pending <= 1'b0;
        if (pv) begin
          prog_mode <= 1'b1;
        end
      end else begin
        if (!pv) begin
          exit_pending <= 1'b1;
        end
        // Leave only at the end of a sync cycle so the programmer stays aligned
        if (exit_pending && sync_end) begin
          prog_mode      <= 1'b0;
          internal_reset <= 1'b1;
        end
      end
    end
  end

  // Command and data shift registers
  always @(posedge clk) begin
    if (!rst_n || !prog_mode) begin
      cmd_shift  <= 4'h0;
      cmd        <= `CMD_IDLE;
      data_shift <= 12'h000;
    end else begin
      if (sample && (cycle != `SYNC_CYCLE) && (cycle <= `LAST_CMD_CYCLE)) begin
        cmd_shift <= new_cmd;
      end
      if (cmd_done) begin
        cmd <= new_cmd;
      end else if (frame_end) begin
        // An undriven line reads 1111, so no action happens by default
        cmd <= `CMD_IDLE;
      end
      if (sample && (cycle >= `FIRST_DATA_CYCLE)) begin
        data_shift <= {data_shift[10:0], sio};
      end
    end
  end

  // Word presented for a read frame
  always @* begin
    next_out = mem_rdata;
    if (new_cmd == `CMD_READ_EXT) begin
      next_out = stored_extended;
    end else if (at_cfg) begin
      next_out = stored_primary;
    end else if (at_id) begin
      next_out = id_words[id_sel];
    end
  end

  // Read path and config read-back
  always @(posedge clk) begin
    if (!rst_n) begin
      out_word             <= 12'hfff;
      reading              <= 1'b0;
      primary_config_word  <= `CFG_RESET;
      extended_config_word <= `CFG_RESET;
    end else begin
      if (!prog_mode) begin
        reading <= 1'b0;
      end else if (cmd_done) begin
        reading <= (new_cmd == `CMD_READ) || (new_cmd == `CMD_READ_EXT);
        if ((new_cmd == `CMD_READ) || (new_cmd == `CMD_READ_EXT)) begin
          out_word <= next_out;
        end
        if ((new_cmd == `CMD_READ) && at_cfg) begin
          primary_config_word <= stored_primary;
        end
        if (new_cmd == `CMD_READ_EXT) begin
          extended_config_word <= stored_extended;
        end
      end else if (frame_end) begin
        reading <= 1'b0;
      end else if (cycle_end && (cycle >= `FIRST_DATA_CYCLE)) begin
        out_word <= {out_word[10:0], 1'b1};
      end
      // Older parts skip the read-back step
      if (old_rev) begin
        primary_config_word  <= stored_primary;
        extended_config_word <= stored_extended;
      end
    end
  end

  // Actions taken at the end of each frame
  always @(posedge clk) begin
    if (!rst_n) begin
      mem_addr        <= `PRIMARY_CFG_2K;
      mem_wdata       <= 12'hfff;
      mem_write       <= 1'b0;
      hold_word       <= 12'hfff;
      stored_primary  <= `CFG_RESET;
      stored_extended <= `CFG_RESET;
      for (i = 0; i < 16; i = i + 1) begin
        id_words[i] <= 12'hfff;
      end
    end else begin
      mem_write <= 1'b0;
      if (!prog_mode) begin
        if (pv) begin
          mem_addr <= cfg_addr(big_part);
        end
      end else if (frame_end) begin
        case (cmd)
          `CMD_LOAD: begin
            hold_word <= data_shift;
          end
          `CMD_INC: begin
            // Config address is all ones, so plus one lands on 000h
            // Data cycles are not looked at here
            if (big_part) begin
              mem_addr <= mem_addr + 13'h0001;
            end else begin
              mem_addr <= {1'b0, mem_addr[11:0] + 12'h001};
            end
          end
          `CMD_PROG: begin
            // Programming only clears bits; repeated frames are harmless
            if (pkg_ok) begin
              if (at_cfg) begin
                stored_primary <= stored_primary & hold_word;
              end else if (at_id) begin
                id_words[id_sel] <= id_words[id_sel] & hold_word;
              end else begin
                mem_wdata <= hold_word;
                mem_write <= 1'b1;
              end
            end
          end
          `CMD_PROG_EXT: begin
            // Left open so a wrong package bit can be corrected
            stored_extended <= stored_extended & hold_word;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Pin pull-down: clock pulse in phase two of every non-sync cycle, data in phases three and four
  always @* begin
    next_oe = 1'b0;
    if (prog_mode) begin
      if ((phase == 2'h1) && (cycle != `SYNC_CYCLE)) begin
        next_oe = 1'b1;
      end else if (phase[1] && reading && (cycle >= `FIRST_DATA_CYCLE)) begin
        next_oe = !out_word[11];
      end
    end
  end

  // One clock of lag is far below a phase period
  always @(posedge clk) begin
    if (!rst_n) begin
      serial_io_pin_oe <= 1'b0;
    end else begin
      serial_io_pin_oe <= next_oe;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/serial_prog_properties.sv ----
// Port-level assertions for the serial programming sequencer
`timescale 1ns/1ps
`default_nettype none
module serial_prog_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Observed ports
  input wire logic        prog_voltage_pin,
  input wire logic        part_4k,
  input wire logic        serial_io_pin_oe,
  input wire logic [12:0] mem_addr,
  input wire logic        mem_write,
  input wire logic        prog_mode,
  input wire logic        internal_reset,
  input wire logic [11:0] primary_config_word,
  input wire logic [11:0] extended_config_word,
  input wire logic [2:0]  clock_trim,
  input wire logic        pins_28
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  entry_addr_a: assert property ($rose(prog_mode) |-> mem_addr == (part_4k ? 13'h1fff : 13'h0fff))
    else $error("pointer not at configuration word on entry");
  entry_pin_a: assert property ($rose(prog_mode) |-> $past(prog_voltage_pin, 4))
    else $error("programming mode without programming voltage");
  addr_step_a: assert property (prog_mode && $past(prog_mode) && mem_addr != $past(mem_addr)
    |-> mem_addr == $past(mem_addr) + 13'h1 || mem_addr == 13'h0) else $error("pointer jumped");
  exit_reset_a: assert property (internal_reset |-> !prog_mode && $past(prog_mode))
    else $error("internal reset outside mode exit");
  fall_reset_a: assert property ($fell(prog_mode) |-> internal_reset ##1 !internal_reset)
    else $error("mode left without one reset pulse");
  write_pulse_a: assert property (mem_write |=> !mem_write)
    else $error("write pulse longer than one clock");
  write_mode_a: assert property (mem_write |-> prog_mode)
    else $error("memory write outside programming mode");
  oe_mode_a: assert property (serial_io_pin_oe |-> prog_mode)
    else $error("line pulled low outside programming mode");
  trim_map_a: assert property (clock_trim == {extended_config_word[11], extended_config_word[9:8]})
    else $error("clock trim does not follow extended word");
  pins_map_a: assert property (pins_28 == extended_config_word[10])
    else $error("package flag does not follow extended word");
  cfg_hold_a: assert property (!prog_mode && !$past(prog_mode) |-> $stable(primary_config_word)
    && $stable(extended_config_word)) else $error("configuration changed outside programming mode");

  cover property ($rose(prog_mode));
  cover property (mem_write);
  cover property (internal_reset);
  cover property (clock_trim != $past(clock_trim));
endmodule
`default_nettype wire

// ---- testbench/isp_programmer.sv ----
// Behavioural external programmer that drives serial frames
`timescale 1ns/1ps
`default_nettype none
module isp_programmer #(
  parameter int phase = 16
) (
  // Clock
  input  wire logic clk,
  // Open-drain line
  input  wire logic line,
  output var logic  drive_low
);
  int   since = 1000;
  int   cyc = 0;
  logic prev = 1'b1;
  logic pulse = 1'b0;

  initial drive_low = 1'b0;

  // Only device pulses make edges we did not cause; the long gap marks the sync cycle
  always @(posedge clk) begin
    prev <= line;
    pulse <= prev && !line && !drive_low;
    if (prev && !line && !drive_low) begin
      cyc <= (since > 6 * phase) ? 1 : cyc + 1;
      since <= 0;
    end else if (since < 1000) begin
      since <= since + 1;
    end
  end

  // Undriven line reads high, so the device sees idle between frames
  task automatic frame(input logic [3:0] cmd, input logic [11:0] wdata, output logic [11:0] rdata);
    logic rd;
    logic b;
    rd = (cmd == 4'h6) || (cmd == 4'h2);
    rdata = 12'h000;
    for (int c = 1; c <= 16; c++) begin
      do @(posedge clk); while (!(pulse && cyc == c));
      b = (c <= 4) ? cmd[4 - c] : wdata[16 - c];
      if (rd && c >= 5) begin
        repeat (2 * phase + phase / 2) @(negedge clk);
        rdata[16 - c] = line;
      end else begin
        repeat (phase) @(negedge clk);
        drive_low = !b;
        repeat (2 * phase - 2) @(negedge clk);
        drive_low = 1'b0;
      end
    end
    repeat (phase) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the serial programming sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        rst_n;
  logic        prog_voltage_pin;
  logic        drive_low;
  logic        serial_io_pin_in;
  logic        serial_io_pin_oe;
  logic        serial_io_pin_out;
  logic [12:0] mem_addr;
  logic [11:0] mem_rdata;
  logic [11:0] mem_wdata;
  logic        mem_write;
  logic        prog_mode;
  logic        internal_reset;
  logic [11:0] primary_config_word;
  logic [11:0] extended_config_word;
  logic [2:0]  clock_trim;
  logic        pins_28;
  logic        part_4k;
  logic        old_revision;
  logic        package_28;
  logic [11:0] rd;
  logic [12:0] last_waddr;
  logic [11:0] last_wdata;
  int          n_writes = 0;
  int          n_errors = 0;
  int          cmp_count = 0;

  // Open drain with pull-up: either side can only pull the line low
  assign serial_io_pin_in = (serial_io_pin_oe ? serial_io_pin_out : 1'b1) && !drive_low;
  assign mem_rdata = mem_addr[11:0] ^ 12'h5a5;

  serial_prog_access serial_prog_access_inst (.clk, .rst_n, .prog_voltage_pin, .serial_io_pin_in,
    .serial_io_pin_out, .serial_io_pin_oe, .part_4k, .old_revision, .package_28,
    .mem_addr, .mem_rdata, .mem_wdata, .mem_write, .prog_mode, .internal_reset,
    .primary_config_word, .extended_config_word, .clock_trim, .pins_28);
  // Short phases keep each frame near a thousand clocks
  defparam serial_prog_access_inst.frame_timer_inst.phase_clks = 11'd16;
  isp_programmer #(.phase(16)) isp_programmer_inst (.clk, .line(serial_io_pin_in), .drive_low);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mem_write) begin
      n_writes <= n_writes + 1;
      last_waddr <= mem_addr;
      last_wdata <= mem_wdata;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic frame(input logic [3:0] cmd, input logic [11:0] wdata);
    isp_programmer_inst.frame(cmd, wdata, rd);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    conclude();
  end

  initial begin
    int i;
    rst_n = 1'b0;
    prog_voltage_pin = 1'b0;
    part_4k = 1'b0;
    old_revision = 1'b0;
    package_28 = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    check(clock_trim, 3'h7);
    check(prog_mode, 1'b0);
    $display("test reset done");
    prog_voltage_pin = 1'b1;
    repeat (10) @(negedge clk);
    check(prog_mode, 1'b1);
    check(mem_addr, 13'h0fff);
    frame(4'h6, 12'h000);
    check(rd, 12'hfff);
    frame(4'h4, 12'ha5c);
    frame(4'h5, 12'h000);
    check(primary_config_word, 12'hfff);
    frame(4'h6, 12'h000);
    check(rd, 12'ha5c);
    check(primary_config_word, 12'ha5c);
    $display("test config done");
    frame(4'h7, 12'h000);
    check(mem_addr, 13'h0000);
    frame(4'h6, 12'h000);
    check(rd, 12'h5a5);
    frame(4'h7, 12'hfff);
    frame(4'h7, 12'hfff);
    check(mem_addr, 13'h0002);
    frame(4'h4, 12'h123);
    // Two frames stand in for the full write time at the short test phase
    repeat (2) frame(4'h5, 12'h000);
    check(n_writes, 32'h2);
    check(last_waddr, 13'h0002);
    check(last_wdata, 12'h123);
    frame(4'hf, 12'h000);
    check(mem_addr, 13'h0002);
    check(n_writes, 32'h2);
    $display("test memory done");
    frame(4'h4, 12'haff);
    frame(4'h3, 12'h000);
    check(clock_trim, 3'h7);
    frame(4'h2, 12'h000);
    check(rd, 12'haff);
    check(extended_config_word, 12'haff);
    check(clock_trim, 3'h6);
    check(pins_28, 1'b0);
    frame(4'h4, 12'h0f0);
    frame(4'h5, 12'h000);
    check(n_writes, 32'h2);
    $display("test extended done");
    prog_voltage_pin = 1'b0;
    // Look between edges so the one-clock reset pulse is seen settled
    for (i = 0; i < 3000 && internal_reset !== 1'b1; i++) @(negedge clk);
    check(internal_reset, 1'b1);
    check(prog_mode, 1'b0);
    @(negedge clk);
    check(internal_reset, 1'b0);
    check(prog_mode, 1'b0);
    $display("test exit done");
    // Second reset: larger part of the older revision
    rst_n = 1'b0;
    part_4k = 1'b1;
    old_revision = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    check(primary_config_word, 12'hfff);
    prog_voltage_pin = 1'b1;
    repeat (10) @(negedge clk);
    check(prog_mode, 1'b1);
    check(mem_addr, 13'h1fff);
    frame(4'h4, 12'h7f3);
    frame(4'h5, 12'h000);
    check(primary_config_word, 12'h7f3);
    frame(4'h7, 12'h000);
    check(mem_addr, 13'h0000);
    $display("test older part done");
    conclude();
  end
endmodule

bind serial_prog_access serial_prog_properties serial_prog_properties_inst (.clk, .rst_n, .prog_voltage_pin,
  .part_4k, .serial_io_pin_oe, .mem_addr, .mem_write, .prog_mode, .internal_reset, .primary_config_word,
  .extended_config_word, .clock_trim, .pins_28);
`default_nettype wire
